//--- hdl/fsc_defines.vh
// Constants shared by the flash erase sequencer and its pin cycle engine
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH

// Flash command codes
`define FSC_CMD_READ_STATUS 8'h70
`define FSC_CMD_BLOCK_SETUP 8'h20
`define FSC_CMD_CHIP_SETUP  8'h30
`define FSC_CMD_CONFIRM     8'hd0
`define FSC_CMD_READ_ARRAY  8'hff

// Operation status bit positions
`define FSC_SB_READY      7
`define FSC_SB_ERASE_ERR  5
`define FSC_SB_WRITE_ERR  4
`define FSC_SB_SUPPLY_LOW 3
`define FSC_SB_SUSPENDED  2
`define FSC_SB_PROTECT    1
`define FSC_SB_VALID_MASK 8'hfe

// Register byte offsets
`define FSC_REG_CTRL     8'h00
`define FSC_REG_ADDR     8'h04
`define FSC_REG_STAT     8'h08
`define FSC_REG_RDATA    8'h0c
`define FSC_REG_IRQ_STAT 8'h10
`define FSC_REG_IRQ_CLR  8'h14
`define FSC_REG_IRQ_EN   8'h18

// Operation codes written to CTRL[2:0]
`define FSC_OP_BLOCK_ERASE  3'h1
`define FSC_OP_CHIP_ERASE   3'h2
`define FSC_OP_STATUS_CHECK 3'h3
`define FSC_OP_CLEAR_STATUS 3'h4
`define FSC_OP_READ_ARRAY   3'h5
`define FSC_OP_READ_ID      3'h6
`define FSC_CTRL_DEFER_BIT  3

// STAT register fields
`define FSC_ST_BUSY       0
`define FSC_ST_SUPPLY_LOW 16
`define FSC_ST_PROTECT    17
`define FSC_ST_SEQ_ERR    18
`define FSC_ST_ERASE_ERR  19
`define FSC_ST_WRITE_ERR  20

// Interrupt bits
`define FSC_IRQ_DONE 0
`define FSC_IRQ_ERR  1

// AXI responses
`define FSC_RESP_OKAY   2'b00
`define FSC_RESP_SLVERR 2'b10

// Pin timing in ns and derived cycle counts (least times round up)
`define FSC_CLK_NS        100
`define FSC_T_SETUP_NS    100
`define FSC_T_PULSE_NS    100
`define FSC_T_ACCESS_NS   200
`define FSC_CYC_SETUP  ((`FSC_T_SETUP_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_CYC_PULSE  ((`FSC_T_PULSE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_CYC_ACCESS ((`FSC_T_ACCESS_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)
`define FSC_SYNC_STAGES 2

`endif

//--- hdl/fsc_bus_cycle.v
// One write or read cycle on the flash parallel pins
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"

module fsc_bus_cycle #(
  parameter AW = 19,
  parameter DW = 16
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          start,
  input  wire          wr,
  input  wire [AW-1:0] addr,
  input  wire [DW-1:0] wdata,
  output reg           done,
  output reg  [DW-1:0] rdata,
  output reg  [AW-1:0] pin_addr,
  output reg  [DW-1:0] pin_dq_o,
  output reg           pin_dq_oe,
  input  wire [DW-1:0] pin_dq_i,
  output reg           pin_ce_n,
  output reg           pin_we_n,
  output reg           pin_oe_n
);
  localparam [1:0] C_IDLE  = 2'b00;
  localparam [1:0] C_SETUP = 2'b01;
  localparam [1:0] C_PULSE = 2'b10;
  localparam [1:0] C_HOLD  = 2'b11;
  localparam integer N_SETUP_I = `FSC_CYC_SETUP;
  localparam integer N_PULSE_I = `FSC_CYC_PULSE;
  localparam integer N_READ_I  = `FSC_CYC_ACCESS + `FSC_SYNC_STAGES;
  localparam [7:0]   N_SETUP   = N_SETUP_I[7:0];
  localparam [7:0]   N_PULSE   = N_PULSE_I[7:0];
  localparam [7:0]   N_READ    = N_READ_I[7:0];

  reg [1:0]    state_q;
  reg [7:0]    cnt_q;
  reg          wr_q;
  reg [DW-1:0] dq_meta_q;
  reg [DW-1:0] dq_sync_q;

  // Data pins come from outside the clock domain
  always @(posedge aclk)
  begin
    dq_meta_q <= pin_dq_i;
    dq_sync_q <= dq_meta_q;
  end

  always @(posedge aclk)
  begin
    done <= 1'b0;
    if (!aresetn)
    begin
      state_q   <= C_IDLE;
      cnt_q     <= 8'h00;
      wr_q      <= 1'b0;
      rdata     <= {DW{1'b0}};
      pin_addr  <= {AW{1'b0}};
      pin_dq_o  <= {DW{1'b0}};
      pin_dq_oe <= 1'b0;
      pin_ce_n  <= 1'b1;
      pin_we_n  <= 1'b1;
      pin_oe_n  <= 1'b1;
    end
    else
    begin
      case (state_q)
        C_IDLE:
        begin
          if (start)
          begin
            wr_q      <= wr;
            pin_addr  <= addr;
            pin_dq_o  <= wdata;
            pin_dq_oe <= wr;
            pin_ce_n  <= 1'b0;
            cnt_q     <= N_SETUP;
            state_q   <= C_SETUP;
          end
        end
        C_SETUP:
        begin
          if (cnt_q <= 8'h01)
          begin
            pin_we_n <= ~wr_q;
            pin_oe_n <= wr_q;
            cnt_q    <= wr_q ? N_PULSE : N_READ;
            state_q  <= C_PULSE;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        C_PULSE:
        begin
          if (cnt_q <= 8'h01)
          begin
            if (!wr_q)
              rdata <= dq_sync_q;
            pin_we_n <= 1'b1;
            pin_oe_n <= 1'b1;
            state_q  <= C_HOLD;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        C_HOLD:
        begin
          pin_dq_oe <= 1'b0;
          pin_ce_n  <= 1'b1;
          done      <= 1'b1;
          state_q   <= C_IDLE;
        end
        default:
          state_q <= C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- hdl/fsc_flash_ctrl.v
// Host-side flash erase sequencer with AXI4-Lite registers and interrupt
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"

// What this block does
// - Write read-status, poll ready bit until set
// - Block erase: setup anywhere, confirm inside block
// - Chip erase: setup, confirm, poll until ready
// - Full check per erase, or after a series of block erases
// - Write read-array after last erase operation
// - Mask reserved bit 0 when evaluating status
// - Clear status after error before anything else
module fsc_flash_ctrl #(
  parameter       AW            = 19,
  parameter       DW            = 16,
  parameter       AXI_AW        = 8,
  parameter [7:0] CMD_CLEAR_ST  = 8'h50,
  parameter [7:0] CMD_READ_ID   = 8'h90
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [AXI_AW-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [AXI_AW-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output reg               irq,
  output wire [AW-1:0]     flash_addr,
  output wire [DW-1:0]     flash_dq_o,
  output wire              flash_dq_oe,
  input  wire [DW-1:0]     flash_dq_i,
  output wire              flash_ce_n,
  output wire              flash_we_n,
  output wire              flash_oe_n
);
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_RSCMD = 4'h1;
  localparam [3:0] ST_POLL  = 4'h2;
  localparam [3:0] ST_SETUP = 4'h3;
  localparam [3:0] ST_CONF  = 4'h4;
  localparam [3:0] ST_CHECK = 4'h5;
  localparam [3:0] ST_CLR   = 4'h6;
  localparam [3:0] ST_FF    = 4'h7;
  localparam [3:0] ST_ARD   = 4'h8;
  localparam [3:0] ST_IDCMD = 4'h9;

  reg [3:0]        state_q;
  reg [2:0]        op_q;
  reg              defer_q;
  reg              after_op_q;
  reg              rd_done_q;
  reg              pend_q;
  reg              start_q;
  reg              busy_q;
  reg [AW-1:0]     addr_q;
  reg [7:0]        opstat_q;
  reg [DW-1:0]     rdata_q;
  reg              e_supply_q;
  reg              e_protect_q;
  reg              e_seq_q;
  reg              e_erase_q;
  reg              e_write_q;
  reg [1:0]        irq_stat_q;
  reg [1:0]        irq_en_q;
  reg [AXI_AW-1:0] aw_q;
  reg [31:0]       wd_q;
  reg [3:0]        ws_q;
  reg              cyc_wr;
  reg [DW-1:0]     cyc_data;
  reg [AW-1:0]     cyc_addr;
  reg              issues;
  wire             cyc_done;
  wire [DW-1:0]    cyc_rdata;
  wire [7:0]       st_masked;
  wire             st_ready;
  wire             any_err;
  wire             commit;
  wire             ctrl_go;
  reg  [1:0]       irq_set;
  reg  [1:0]       irq_clr;
  reg  [31:0]      rd_mux;
  reg              rd_ok;

  // Reserved status bit is dropped before any decision
  assign st_masked = cyc_rdata[7:0] & `FSC_SB_VALID_MASK;
  assign st_ready  = st_masked[`FSC_SB_READY];
  assign any_err   = st_masked[`FSC_SB_ERASE_ERR] | st_masked[`FSC_SB_WRITE_ERR]
                   | st_masked[`FSC_SB_SUPPLY_LOW] | st_masked[`FSC_SB_PROTECT];

  // What each state puts on the pins
  always @*
  begin
    issues   = 1'b1;
    cyc_wr   = 1'b1;
    cyc_addr = {AW{1'b0}};
    cyc_data = {DW{1'b0}};
    case (state_q)
      ST_RSCMD: cyc_data = {{(DW-8){1'b0}}, `FSC_CMD_READ_STATUS};
      ST_POLL:  cyc_wr   = 1'b0;
      ST_SETUP:
      begin
        if (op_q == `FSC_OP_CHIP_ERASE)
          cyc_data = {{(DW-8){1'b0}}, `FSC_CMD_CHIP_SETUP};
        else
          cyc_data = {{(DW-8){1'b0}}, `FSC_CMD_BLOCK_SETUP};
      end
      ST_CONF:
      begin
        cyc_data = {{(DW-8){1'b0}}, `FSC_CMD_CONFIRM};
        if (op_q == `FSC_OP_BLOCK_ERASE)
          cyc_addr = addr_q;
      end
      ST_CLR:   cyc_data = {{(DW-8){1'b0}}, CMD_CLEAR_ST};
      ST_FF:    cyc_data = {{(DW-8){1'b0}}, `FSC_CMD_READ_ARRAY};
      ST_IDCMD: cyc_data = {{(DW-8){1'b0}}, CMD_READ_ID};
      ST_ARD:
      begin
        cyc_wr   = 1'b0;
        cyc_addr = addr_q;
      end
      default:  issues = 1'b0;
    endcase
  end

  // AXI write slot: both halves collected, then one commit
  assign commit  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign ctrl_go = commit & (aw_q == `FSC_REG_CTRL) & ws_q[0] & ~busy_q;

  always @*
  begin
    irq_set = 2'b00;
    irq_clr = 2'b00;
    if (commit && aw_q == `FSC_REG_IRQ_CLR && ws_q[0])
      irq_clr = wd_q[1:0];
    if (state_q == ST_CHECK)
      irq_set[`FSC_IRQ_ERR] = any_err;
    if (pend_q && cyc_done && ((state_q == ST_FF && !(op_q == `FSC_OP_READ_ARRAY && !rd_done_q))
        || (state_q == ST_ARD && op_q != `FSC_OP_READ_ID)
        || (state_q == ST_CLR && op_q == `FSC_OP_CLEAR_STATUS)))
      irq_set[`FSC_IRQ_DONE] = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FSC_RESP_OKAY;
      aw_q          <= {AXI_AW{1'b0}};
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      addr_q        <= {AW{1'b0}};
      irq_en_q      <= 2'b00;
      irq_stat_q    <= 2'b00;
      irq           <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q          <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_q         <= s_axi_wdata;
        ws_q         <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (commit)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `FSC_RESP_OKAY;
        case (aw_q)
          `FSC_REG_CTRL, `FSC_REG_IRQ_CLR: ;
          `FSC_REG_ADDR:
          begin
            if (!busy_q && ws_q == 4'hf)
              addr_q <= wd_q[AW-1:0];
          end
          `FSC_REG_IRQ_EN:
          begin
            if (ws_q[0])
              irq_en_q <= wd_q[1:0];
          end
          default: s_axi_bresp <= `FSC_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // New events win over a clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq        <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // AXI read channel
  always @*
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      `FSC_REG_CTRL:     rd_mux = {28'h000_0000, defer_q, op_q};
      `FSC_REG_ADDR:     rd_mux[AW-1:0] = addr_q;
      `FSC_REG_STAT:
      begin
        rd_mux[`FSC_ST_BUSY]       = busy_q;
        rd_mux[15:8]               = opstat_q;
        rd_mux[`FSC_ST_SUPPLY_LOW] = e_supply_q;
        rd_mux[`FSC_ST_PROTECT]    = e_protect_q;
        rd_mux[`FSC_ST_SEQ_ERR]    = e_seq_q;
        rd_mux[`FSC_ST_ERASE_ERR]  = e_erase_q;
        rd_mux[`FSC_ST_WRITE_ERR]  = e_write_q;
      end
      `FSC_REG_RDATA:    rd_mux[DW-1:0] = rdata_q;
      `FSC_REG_IRQ_STAT: rd_mux[1:0] = irq_stat_q;
      `FSC_REG_IRQ_CLR:  rd_mux = 32'h0000_0000;
      `FSC_REG_IRQ_EN:   rd_mux[1:0] = irq_en_q;
      default:           rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FSC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Command sequencer
  always @(posedge aclk)
  begin
    start_q <= 1'b0;
    if (!aresetn)
    begin
      state_q     <= ST_IDLE;
      op_q        <= 3'h0;
      defer_q     <= 1'b0;
      after_op_q  <= 1'b0;
      rd_done_q   <= 1'b0;
      pend_q      <= 1'b0;
      busy_q      <= 1'b0;
      opstat_q    <= 8'h00;
      rdata_q     <= {DW{1'b0}};
      e_supply_q  <= 1'b0;
      e_protect_q <= 1'b0;
      e_seq_q     <= 1'b0;
      e_erase_q   <= 1'b0;
      e_write_q   <= 1'b0;
    end
    else if (state_q == ST_IDLE)
    begin
      if (ctrl_go)
      begin
        op_q       <= wd_q[2:0];
        defer_q    <= wd_q[`FSC_CTRL_DEFER_BIT];
        rd_done_q  <= 1'b0;
        after_op_q <= (wd_q[2:0] == `FSC_OP_STATUS_CHECK);
        busy_q     <= 1'b1;
        case (wd_q[2:0])
          `FSC_OP_BLOCK_ERASE, `FSC_OP_CHIP_ERASE, `FSC_OP_STATUS_CHECK:
            state_q <= ST_RSCMD;
          `FSC_OP_CLEAR_STATUS: state_q <= ST_CLR;
          `FSC_OP_READ_ARRAY:   state_q <= ST_FF;
          `FSC_OP_READ_ID:      state_q <= ST_IDCMD;
          default:              busy_q  <= 1'b0;
        endcase
      end
    end
    else if (state_q == ST_CHECK)
    begin
      // Device flags accumulate, so a deferred check sees the whole series
      e_supply_q  <= st_masked[`FSC_SB_SUPPLY_LOW];
      e_protect_q <= st_masked[`FSC_SB_PROTECT];
      e_seq_q     <= st_masked[`FSC_SB_ERASE_ERR] & st_masked[`FSC_SB_WRITE_ERR];
      e_erase_q   <= st_masked[`FSC_SB_ERASE_ERR] & ~st_masked[`FSC_SB_WRITE_ERR];
      e_write_q   <= st_masked[`FSC_SB_WRITE_ERR] & ~st_masked[`FSC_SB_ERASE_ERR];
      state_q     <= any_err ? ST_CLR : ST_FF;
    end
    else if (issues && !pend_q)
    begin
      pend_q  <= 1'b1;
      start_q <= 1'b1;
    end
    else if (pend_q && cyc_done)
    begin
      pend_q <= 1'b0;
      case (state_q)
        ST_RSCMD: state_q <= ST_POLL;
        ST_POLL:
        begin
          // Busy device keeps returning status; keep polling until ready
          opstat_q <= st_masked;
          if (st_ready)
          begin
            if (!after_op_q)
              state_q <= ST_SETUP;
            else if (defer_q && op_q == `FSC_OP_BLOCK_ERASE)
              state_q <= ST_FF;
            else
              state_q <= ST_CHECK;
          end
        end
        ST_SETUP: state_q <= ST_CONF;
        ST_CONF:
        begin
          after_op_q <= 1'b1;
          state_q    <= ST_POLL;
        end
        ST_CLR:
        begin
          if (op_q == `FSC_OP_CLEAR_STATUS)
          begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
          else
            state_q <= ST_FF;
        end
        ST_FF:
        begin
          if (op_q == `FSC_OP_READ_ARRAY && !rd_done_q)
            state_q <= ST_ARD;
          else
          begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        ST_IDCMD: state_q <= ST_ARD;
        ST_ARD:
        begin
          rdata_q   <= cyc_rdata;
          rd_done_q <= 1'b1;
          if (op_q == `FSC_OP_READ_ID)
            state_q <= ST_FF;
          else
          begin
            busy_q  <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  fsc_bus_cycle #(
    .AW (AW),
    .DW (DW)
  ) u_cycle (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (start_q),
    .wr        (cyc_wr),
    .addr      (cyc_addr),
    .wdata     (cyc_data),
    .done      (cyc_done),
    .rdata     (cyc_rdata),
    .pin_addr  (flash_addr),
    .pin_dq_o  (flash_dq_o),
    .pin_dq_oe (flash_dq_oe),
    .pin_dq_i  (flash_dq_i),
    .pin_ce_n  (flash_ce_n),
    .pin_we_n  (flash_we_n),
    .pin_oe_n  (flash_oe_n)
  );
endmodule
`default_nettype wire

//--- sim/fsc_flash_model.sv
// Behavioural parallel flash device answering the sequencer pins
`timescale 1ns/100ps
`default_nettype none
module fsc_flash_model #(
  parameter int BUSY = 5
) (
  input  wire logic        aclk,
  input  wire logic [18:0] flash_addr,
  input  wire logic [15:0] flash_dq_o,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic [7:0]  inj,
  input  wire logic        lock,
  output var  logic [15:0] flash_dq_i,
  output var  logic [18:0] conf_addr,
  output var  int          clr_cnt
);
  logic [7:0]  flags = 8'h00;
  logic [7:0]  pend = 8'h00;
  logic [1:0]  mode = 2'd1;
  logic [15:0] last = 16'h0000;
  int          busy = 0;
  initial clr_cnt = 0;
  // Commands latch on the rising write strobe
  always @(posedge flash_we_n)
    if (flash_ce_n === 1'b0)
    begin
      if (pend != 8'h00)
      begin
        if (flash_dq_o[7:0] == 8'hd0)
        begin
          busy = BUSY;
          conf_addr = flash_addr;
        end
        else
          flags = flags | 8'h30;
        pend = 8'h00;
        mode = 2'd1;
      end
      else
        case (flash_dq_o[7:0])
          8'h70: mode = 2'd1;
          8'h20, 8'h30: pend = flash_dq_o[7:0];
          8'h50:
          begin
            flags = 8'h00;
            clr_cnt++;
          end
          8'hff: mode = 2'd0;
          8'h90: mode = 2'd2;
          default: ;
        endcase
    end
  // Injected faults land as the erase ends and then stick
  always @(posedge aclk)
    if (busy > 0)
    begin
      if (busy == 1)
        flags = flags | inj;
      busy = busy - 1;
    end
  // Reserved bit reads 1 so the host must mask it; released bus shows inverse
  always @*
    if (!flash_ce_n && !flash_oe_n)
    begin
      if (mode == 2'd0 && busy == 0)
        flash_dq_i = ~flash_addr[15:0];
      else if (mode == 2'd2)
        flash_dq_i = {15'h0000, lock};
      else
        flash_dq_i = {8'h00, busy == 0, flags[6:1], 1'b1};
      last = flash_dq_i;
    end
    else
      flash_dq_i = ~last;
endmodule
`default_nettype wire

//--- sim/fsc_flash_ctrl_props.sv
// Port checker for the flash erase sequencer
`timescale 1ns/100ps
`default_nettype none
module fsc_flash_ctrl_props #(
  parameter AW = 19
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [AW-1:0] flash_addr,
  input wire logic          flash_dq_oe,
  input wire logic          flash_ce_n,
  input wire logic          flash_we_n,
  input wire logic          flash_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wr_resp_time: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after acceptance");
  a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_rd_data_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_wr_resp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while data pending");
  a_strobe_excl: assert property (!flash_we_n |-> flash_oe_n)
    else $error("write and read strobes low together");
  a_strobe_chip: assert property (!(flash_we_n && flash_oe_n) |-> !flash_ce_n)
    else $error("strobe low without chip enable");
  a_write_drives: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("data pins not driven during write");
  a_read_released: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data pins driven during read");
  a_write_pulse: assert property (
    $fell(flash_we_n) |=> flash_we_n && $stable(flash_addr))
    else $error("write pulse length or address wrong");
  a_read_pulse: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*4])
    else $error("read pulse too short");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'b10);
  cover property ($fell(flash_we_n));
endmodule
bind fsc_flash_ctrl fsc_flash_ctrl_props #(.AW(AW)) fsc_flash_ctrl_props_i (.*);
`default_nettype wire

//--- sim/test_fsc_flash_ctrl.sv
// Self-checking bench for the flash erase sequencer
`timescale 1ns/100ps
`default_nettype none
module test_fsc_flash_ctrl;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         irq, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
  wire  [18:0] flash_addr, conf_addr;
  wire  [15:0] flash_dq_o, flash_dq_i;
  logic [7:0]  inj = 8'h00;
  logic        lock = 1'b0;
  logic [1:0]  en = 2'b00;
  logic [1:0]  r;
  logic [31:0] v;
  int          clr_cnt, n0, error_cnt = 0, checks_done = 0, cyc = 0;
  logic [7:0]  fl [6] = '{8'h08, 8'h02, 8'h30, 8'h20, 8'h10, 8'h04};
  logic [4:0]  eb [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
  fsc_flash_ctrl fsc_flash_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .flash_addr, .flash_dq_o, .flash_dq_oe,
    .flash_dq_i, .flash_ce_n, .flash_we_n, .flash_oe_n);
  fsc_flash_model fsc_flash_model_i (.aclk, .flash_addr, .flash_dq_o, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .inj, .lock, .flash_dq_i, .conf_addr, .clr_cnt);
  initial
    forever #50 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask
  // Start an operation, wait for done, compare interrupt state, then clear it
  task automatic op(input logic [31:0] c, input logic [1:0] e);
    int k;
    wr(8'h00, c, 2'b00);
    k = 0;
    do
    begin
      rd(8'h10);
      k++;
    end while (v[0] !== 1'b1 && k < 500);
    chk("irq_stat", e, v);
    chk("irq", |(e & en), irq);
    wr(8'h14, 32'h0000_0003, 2'b00);
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("stat", 8'h08, 32'h0000_0000);
    rc("irq_stat", 8'h10, 32'h0000_0000);
    rc("irq_en", 8'h18, 32'h0000_0000);
    rd(8'h1c);
    chk("unmapped rresp", 2'b10, r);
    wr(8'h1c, 32'h0000_0000, 2'b10);
    $display("test reset done");
    en = 2'b11;
    wr(8'h18, 32'h0000_0003, 2'b00);
    wr(8'h04, 32'h0004_5678, 2'b00);
    op(32'h0000_0001, 2'b01);
    chk("confirm addr", 32'h0004_5678, conf_addr);
    rc("stat clean", 8'h08, 32'h0000_8000);
    $display("test block erase done");
    for (int i = 0; i < 6; i++)
    begin
      inj <= fl[i];
      n0 = clr_cnt;
      op(32'h0000_0002, (fl[i] & 8'h3a) != 8'h00 ? 2'b11 : 2'b01);
      rc("stat err", 8'h08, {11'h000, eb[i], 8'h80 | fl[i], 8'h00});
      chk("clear sent", n0 + ((fl[i] & 8'h3a) != 8'h00), clr_cnt);
    end
    $display("test error flags done");
    inj <= 8'h08;
    n0 = clr_cnt;
    op(32'h0000_0009, 2'b01);
    inj <= 8'h00;
    op(32'h0000_0009, 2'b01);
    chk("no clear deferred", n0, clr_cnt);
    op(32'h0000_0003, 2'b11);
    rc("stat sticky", 8'h08, 32'h0001_8c00);
    chk("clear after check", n0 + 1, clr_cnt);
    n0 = clr_cnt;
    op(32'h0000_0004, 2'b01);
    chk("clear op", n0 + 1, clr_cnt);
    $display("test deferred check done");
    wr(8'h04, 32'h0000_0abc, 2'b00);
    op(32'h0000_0005, 2'b01);
    rc("array word", 8'h0c, 32'h0000_f543);
    lock <= 1'b1;
    op(32'h0000_0006, 2'b01);
    rc("id word", 8'h0c, 32'h0000_0001);
    en = 2'b00;
    wr(8'h18, 32'h0000_0000, 2'b00);
    inj <= 8'h20;
    op(32'h0000_0002, 2'b11);
    rc("irq cleared", 8'h10, 32'h0000_0000);
    $display("test read and interrupt done");
    finish_test();
  end
endmodule
`default_nettype wire
